/* rtl/ingress_cfg.svh */
// constants for the ingress classifier: table sizes, field positions, tree states, command codes
`ifndef INGRESS_CFG_SVH
`define INGRESS_CFG_SVH
`define NUM_PORTS        3
`define VLAN_ENTRIES     16
`define DS_ENTRIES       64
`define VID_NULL         12'h000
`define VID_RESERVED     12'hfff
`define TOS_PREC_MSB     7
`define TOS_PREC_LSB     5
`define TOS_DS_MSB       7
`define TOS_DS_LSB       2
`define STATE_FORWARD    2'h0
`define STATE_BLOCK      2'h1
`define STATE_LEARN      2'h2
`define STATE_LISTEN     2'h3
`define PORT_STATE_RST   6'h00
`define REMAP_RST        24'hfac688
`define TC_MAP_RST       16'hfa50
`define PORT_DEFAULT_VLAN_ID_RST         12'h001
`define PORT_DEFAULT_VLAN_ID_PRIO_RST    3'h0
`define CMD_OP_WRITE     1'b1
`define CMD_OP_READ      1'b0
`define CFG_EN_DA_BIT    0
`define CFG_EN_DS_BIT    1
`define CFG_EN_PREC_BIT  2
`define CFG_EN_VLANP_BIT 3
`define CFG_VLAN_EN_BIT  4
`define CFG_MEMB_CHK_BIT 5
`define CFG_RST          6'h00
`endif

/* rtl/ingress_pkg.sv */
// types shared by the ingress classifier modules
package ingress_pkg;
    typedef logic [1:0]  queue_t;
    typedef logic [2:0]  prio_t;
    typedef logic [11:0] vid_t;
    typedef logic [2:0]  portset_t;
    typedef logic [1:0]  tree_state_t;
    typedef enum logic [2:0] {
        SRC_STATIC,
        SRC_PRECEDENCE,
        SRC_DIFFSERV,
        SRC_VLAN,
        SRC_DEFAULT
    } prio_src_t;
    typedef enum {
        CMD_IDLE,
        CMD_BUSY
    } cmd_state_t;
endpackage : ingress_pkg

/* rtl/table_port_if.sv */
// indirect table access bundle between the classifier and its table engine
`timescale 1ns/10ps
`default_nettype none
interface table_port_if;
    logic        req;
    logic        wr;
    logic [3:0]  idx;
    logic [30:0] wdata;
    logic [30:0] rdata;
    logic        busy;
    modport ctrl (output req, output wr, output idx, output wdata, input rdata, input busy);
    modport eng  (input req, input wr, input idx, input wdata, output rdata, output busy);
endinterface : table_port_if
`default_nettype wire

/* rtl/vlan_table_engine.sv */
// sixteen-entry vlan table with indirect command port and a parallel lookup
`timescale 1ns/10ps
`default_nettype none
`include "ingress_cfg.svh"
module vlan_table_engine
    import ingress_pkg::*;
(
    // clock and reset
    input  wire logic     sys_clk,
    input  wire logic     sys_rst,
    // host command side
    table_port_if.eng     cmd,
    // lookup side
    input  wire vid_t     look_vid,
    output logic          look_hit,
    output portset_t      look_member,
    output portset_t      look_untag
);
    // entry: [30] valid, [29:18] vid, [17:15] member, [14:12] untag, rest unused
    logic [30:0] entry_ff [`VLAN_ENTRIES];
    cmd_state_t  st_ff;
    logic [30:0] rdata_ff;
    logic [`VLAN_ENTRIES-1:0] hit_vec;
    logic [3:0]  hit_idx;

    // one cycle busy per command, write lands on entry to busy, read data latched on exit
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            st_ff    <= CMD_IDLE;
            rdata_ff <= '0;
        end else begin
            unique case (st_ff)
                CMD_IDLE: if (cmd.req) st_ff <= CMD_BUSY;
                CMD_BUSY: begin
                    st_ff <= CMD_IDLE;
                    rdata_ff <= entry_ff[cmd.idx];
                end
            endcase
        end
    end

    // table storage, every entry invalid after reset
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            for (int i = 0; i < `VLAN_ENTRIES; i++) entry_ff[i] <= '0;
        end else if (st_ff == CMD_IDLE && cmd.req && cmd.wr == `CMD_OP_WRITE) begin
            entry_ff[cmd.idx] <= cmd.wdata;
        end
    end

    assign cmd.busy  = (st_ff == CMD_BUSY);
    assign cmd.rdata = rdata_ff;

    // parallel compare of all entries, lowest index wins
    for (genvar g = 0; g < `VLAN_ENTRIES; g++) begin : g_cmp
        assign hit_vec[g] = entry_ff[g][30] && (entry_ff[g][29:18] == look_vid);
    end
    always_comb begin
        hit_idx = '0;
        for (int i = `VLAN_ENTRIES-1; i >= 0; i--) if (hit_vec[i]) hit_idx = 4'(i);
    end
    assign look_hit    = |hit_vec;
    assign look_member = look_hit ? entry_ff[hit_idx][17:15] : 3'h0;
    assign look_untag  = look_hit ? entry_ff[hit_idx][14:12] : 3'h0;

    a_busy_one_cycle: assert property (@(posedge sys_clk) disable iff (sys_rst)
        cmd.busy |=> !cmd.busy) else $error("vlan busy lasted more than one cycle");
endmodule : vlan_table_engine
`default_nettype wire

/* rtl/ingress_classifier.sv */
// ingress classifier: queue selection, vlan resolution and spanning tree gating
`timescale 1ns/10ps
`default_nettype none
`include "ingress_cfg.svh"

// Function
// - queue from static, precedence, diffserv, vlan, default
// - non-static sources pass traffic class map
// - static priority selects queue directly
// - default priority stored with port default vid
// - precedence is top three tos bits
// - diffserv table indexed by top six bits
// - diffserv table uninitialised, host fills first
// - diffserv table reached by indirect commands
// - vlan priority remapped per ingress port
// - sixteen vlan entries, vid member untag
// - valid tagged vid searches vlan table
// - missing vid gives empty membership
// - empty membership filters when checking or unknown
// - untagged or vid zero uses port default
// - membership for checks, untag only hybrid
// - two-bit tree state, disabled equals blocking
// - non-forwarding discards receive and transmit
// - learning on only learning and forwarding
// - forwarding state passes traffic normally
// - static plus age entry bypasses tree state
// - filter on non-forwarding source or destination
// - vid fff filtered when vlan enabled
module ingress_classifier
    import ingress_pkg::*;
(
    // clock and reset
    input  wire logic        sys_clk,
    input  wire logic        sys_rst,
    // global configuration
    input  wire logic [5:0]  global_ingress_config,
    input  wire logic [5:0]  port_tree_state_reg,
    input  wire logic [7:0]  port0_priority_remap,
    input  wire logic [7:0]  port1_priority_remap,
    input  wire logic [7:0]  port2_priority_remap,
    input  wire logic [15:0] traffic_class_map,
    input  wire logic [2:0]  hybrid_ports,
    // port default vid table writes
    input  wire logic        port_default_vlan_id_wr,
    input  wire logic [1:0]  port_default_vlan_id_port,
    input  wire logic [14:0] port_default_vlan_id_wdata,
    // vlan table indirect access
    input  wire logic        vlan_table_command,
    input  wire logic        vlan_table_cmd_wr,
    input  wire logic [3:0]  vlan_table_cmd_idx,
    input  wire logic [30:0] vlan_table_write_data,
    output logic [30:0]      vlan_table_read_data,
    output logic             vlan_table_cmd_status,
    // diffserv table indirect access
    input  wire logic        ds_table_command,
    input  wire logic        ds_table_cmd_wr,
    input  wire logic [5:0]  ds_table_cmd_idx,
    input  wire logic [2:0]  ds_table_write_data,
    output logic [2:0]       ds_table_read_data,
    output logic             ds_table_cmd_status,
    // packet descriptor from port receive
    input  wire logic        pkt_valid,
    input  wire logic [1:0]  pkt_src_port,
    input  wire logic [2:0]  pkt_dst_ports,
    input  wire logic        pkt_da_found,
    input  wire logic        pkt_da_static,
    input  wire logic        pkt_da_age,
    input  wire logic [1:0]  pkt_da_queue,
    input  wire logic        pkt_tagged,
    input  wire logic [11:0] pkt_vid,
    input  wire logic [2:0]  pkt_tag_prio,
    input  wire logic        pkt_is_ipv4,
    input  wire logic        pkt_is_ipv6,
    input  wire logic [7:0]  pkt_tos,
    // classification result
    output logic             res_valid,
    output logic [1:0]       res_queue,
    output logic [2:0]       res_src,
    output logic [2:0]       res_member,
    output logic [2:0]       res_untag,
    output logic [2:0]       res_tx_ports,
    output logic             res_filter,
    output logic             res_learn,
    output logic [11:0]      res_vid
);
    // ****************************************
    // port default vid and priority storage
    // ****************************************
    logic [14:0] port_default_vlan_id_ff [`NUM_PORTS];

    // entries hold {priority, vid}, writes from the host command path
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            for (int i = 0; i < `NUM_PORTS; i++) port_default_vlan_id_ff[i] <= {`PORT_DEFAULT_VLAN_ID_PRIO_RST, `PORT_DEFAULT_VLAN_ID_RST};
        end else if (port_default_vlan_id_wr && port_default_vlan_id_port < 2'(`NUM_PORTS)) begin
            port_default_vlan_id_ff[port_default_vlan_id_port] <= port_default_vlan_id_wdata;
        end
    end

    // ****************************************
    // diffserv table, no reset on purpose
    // ****************************************
    logic [2:0]  ds_ff [`DS_ENTRIES];
    logic [2:0]  ds_rd_ff;
    logic        ds_busy_ff;

    // contents stay undefined until the host writes every entry
    always_ff @(posedge sys_clk) begin
        if (ds_table_command && !ds_busy_ff && ds_table_cmd_wr == `CMD_OP_WRITE)
            ds_ff[ds_table_cmd_idx] <= ds_table_write_data;
    end

    // one cycle status busy per command, read data latched on completion
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            ds_busy_ff <= 1'b0;
            ds_rd_ff   <= 3'h0;
        end else begin
            ds_busy_ff <= ds_table_command && !ds_busy_ff;
            if (ds_busy_ff) ds_rd_ff <= ds_ff[ds_table_cmd_idx];
        end
    end
    assign ds_table_cmd_status = ds_busy_ff;
    assign ds_table_read_data  = ds_rd_ff;

    // ****************************************
    // vlan table engine
    // ****************************************
    table_port_if vtab ();
    logic       look_hit;
    portset_t   look_member;
    portset_t   look_untag;
    vid_t       eff_vid;

    assign vtab.req   = vlan_table_command;
    assign vtab.wr    = vlan_table_cmd_wr;
    assign vtab.idx   = vlan_table_cmd_idx;
    assign vtab.wdata = vlan_table_write_data;
    assign vlan_table_read_data  = vtab.rdata;
    assign vlan_table_cmd_status = vtab.busy;

    vlan_table_engine u_vtab (
        .sys_clk     (sys_clk),
        .sys_rst     (sys_rst),
        .cmd         (vtab.eng),
        .look_vid    (eff_vid),
        .look_hit    (look_hit),
        .look_member (look_member),
        .look_untag  (look_untag)
    );

    // ****************************************
    // vlan resolution
    // ****************************************
    wire        use_default = !pkt_tagged || (pkt_vid == `VID_NULL);
    wire [14:0] src_port_default_vlan_id    = port_default_vlan_id_ff[pkt_src_port];
    wire        vid_reserved = pkt_tagged && (pkt_vid == `VID_RESERVED);
    wire        vlan_en     = global_ingress_config[`CFG_VLAN_EN_BIT];
    wire        memb_chk    = global_ingress_config[`CFG_MEMB_CHK_BIT];
    assign eff_vid = use_default ? src_port_default_vlan_id[11:0] : pkt_vid;
    wire [2:0]  member = (vid_reserved) ? 3'h0 : look_member;
    wire [2:0]  untag  = look_untag & hybrid_ports;

    // ****************************************
    // priority sources
    // ****************************************
    wire [2:0] prec_prio = pkt_tos[`TOS_PREC_MSB:`TOS_PREC_LSB];
    wire [5:0] ds_index  = pkt_tos[`TOS_DS_MSB:`TOS_DS_LSB];
    wire [2:0] ds_prio   = ds_ff[ds_index];
    wire [7:0] remap_row = (pkt_src_port == 2'h0) ? port0_priority_remap :
                           (pkt_src_port == 2'h1) ? port1_priority_remap : port2_priority_remap;
    // the ingress port's own row sets the top bit of the regenerated priority, the tag keeps the low bits
    wire [2:0] regen_prio = {remap_row[pkt_tag_prio], pkt_tag_prio[1:0]};
    wire [2:0] dflt_prio = src_port_default_vlan_id[14:12];

    // ****************************************
    // source selection and traffic class map
    // ****************************************
    wire en_da   = global_ingress_config[`CFG_EN_DA_BIT];
    wire en_ds   = global_ingress_config[`CFG_EN_DS_BIT];
    wire en_prec = global_ingress_config[`CFG_EN_PREC_BIT];
    wire en_vlnp = global_ingress_config[`CFG_EN_VLANP_BIT];
    wire is_ip   = pkt_is_ipv4 || pkt_is_ipv6;
    prio_src_t sel_src;
    logic [2:0] sel_prio;

    // fixed precedence: static da, diffserv, precedence, vlan tag, port default
    always_comb begin
        if (en_da && pkt_da_found && pkt_da_static) begin
            sel_src = SRC_STATIC;
            sel_prio = {1'b0, pkt_da_queue};
        end else if (en_ds && is_ip) begin
            sel_src = SRC_DIFFSERV;
            sel_prio = ds_prio;
        end else if (en_prec && pkt_is_ipv4) begin
            sel_src = SRC_PRECEDENCE;
            sel_prio = prec_prio;
        end else if (en_vlnp && pkt_tagged) begin
            sel_src = SRC_VLAN;
            sel_prio = regen_prio;
        end else begin
            sel_src = SRC_DEFAULT;
            sel_prio = dflt_prio;
        end
    end
    wire [1:0] tc_queue  = traffic_class_map[sel_prio*2 +: 2];
    wire [1:0] nxt_queue = (sel_src == SRC_STATIC) ? pkt_da_queue : tc_queue;

    // ****************************************
    // spanning tree gating and filtering
    // ****************************************
    logic [`NUM_PORTS-1:0] port_fwd;
    logic [`NUM_PORTS-1:0] port_learn;
    for (genvar p = 0; p < `NUM_PORTS; p++) begin : g_tree
        wire [1:0] st = port_tree_state_reg[p*2 +: 2];
        assign port_fwd[p]   = (st == `STATE_FORWARD);
        assign port_learn[p] = (st == `STATE_FORWARD) || (st == `STATE_LEARN);
    end
    wire       override  = pkt_da_found && pkt_da_static && pkt_da_age;
    wire       src_fwd   = port_fwd[pkt_src_port] || override;
    wire [2:0] src_bit   = 3'h1 << pkt_src_port;
    wire [2:0] base_dst  = pkt_da_found ? pkt_dst_ports : ~src_bit;
    wire [2:0] vlan_dst  = vlan_en ? (base_dst & member) : base_dst;
    wire [2:0] nxt_tx    = (vlan_dst & ~src_bit) & (override ? 3'h7 : port_fwd);
    wire       memb_fail = vlan_en && memb_chk && ((member & pkt_dst_ports) != pkt_dst_ports
                           || member == 3'h0);
    wire       unk_empty = vlan_en && !pkt_da_found && (nxt_tx == 3'h0);
    wire       nxt_filter = !src_fwd || (vlan_en && vid_reserved) || memb_fail
                            || unk_empty || (nxt_tx == 3'h0);

    // ****************************************
    // result register
    // ****************************************
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            res_valid    <= 1'b0;
            res_queue    <= 2'h0;
            res_src      <= 3'h0;
            res_member   <= 3'h0;
            res_untag    <= 3'h0;
            res_tx_ports <= 3'h0;
            res_filter   <= 1'b0;
            res_learn    <= 1'b0;
            res_vid      <= 12'h000;
        end else begin
            res_valid    <= pkt_valid;
            res_queue    <= nxt_queue;
            res_src      <= sel_src;
            res_member   <= member;
            res_untag    <= untag;
            res_tx_ports <= nxt_filter ? 3'h0 : nxt_tx;
            res_filter   <= nxt_filter;
            res_learn    <= pkt_valid && port_learn[pkt_src_port];
            res_vid      <= eff_vid;
        end
    end

    // ****************************************
    // assertions
    // ****************************************
    a_static_direct: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (pkt_valid && en_da && pkt_da_found && pkt_da_static) |=> res_queue == $past(pkt_da_queue))
        else $error("static priority did not select queue directly");
    a_block_discard: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (pkt_valid && !override && !port_fwd[pkt_src_port]) |=> res_filter && res_tx_ports == 3'h0)
        else $error("packet from non-forwarding port not filtered");
    a_learn_gate: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (pkt_valid && port_tree_state_reg[pkt_src_port*2 +: 2] inside {`STATE_BLOCK, `STATE_LISTEN})
        |=> !res_learn) else $error("learning on blocked port");
    a_reserved_vid: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (pkt_valid && vlan_en && pkt_tagged && pkt_vid == `VID_RESERVED) |=> res_filter)
        else $error("vid fff not filtered");
    a_default_vid: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (pkt_valid && !pkt_tagged) |=> res_vid == $past(src_port_default_vlan_id[11:0]))
        else $error("untagged packet missed default vid");
    a_foreign_empty: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (pkt_valid && !look_hit) |=> res_member == 3'h0)
        else $error("foreign vlan gave members");
    a_untag_hybrid: assert property (@(posedge sys_clk) disable iff (sys_rst)
        pkt_valid |=> (res_untag & ~$past(hybrid_ports)) == 3'h0)
        else $error("untag on non-hybrid port");
    a_tc_map: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (pkt_valid && sel_src == SRC_DEFAULT) |=> res_queue == $past(traffic_class_map[dflt_prio*2 +: 2]))
        else $error("default priority not mapped");
    a_ds_busy: assert property (@(posedge sys_clk) disable iff (sys_rst)
        ds_table_cmd_status |=> !ds_table_cmd_status)
        else $error("diffserv busy too long");
    c_static: cover property (@(posedge sys_clk) disable iff (sys_rst) pkt_valid && sel_src == SRC_STATIC);
    c_vlan: cover property (@(posedge sys_clk) disable iff (sys_rst) pkt_valid && sel_src == SRC_VLAN);
    c_override: cover property (@(posedge sys_clk) disable iff (sys_rst) pkt_valid && override && !port_fwd[pkt_src_port]);
    c_hit: cover property (@(posedge sys_clk) disable iff (sys_rst) pkt_valid && look_hit);
endmodule : ingress_classifier
`default_nettype wire

/* verification/host_model.sv */
// host software model driving the indirect vlan and diffserv table commands
`timescale 1ns/10ps
`default_nettype none
module host_model (
    // clock
    input  wire logic        sys_clk,
    // vlan table command port
    output logic             vlan_table_command,
    output logic             vlan_table_cmd_wr,
    output logic [3:0]       vlan_table_cmd_idx,
    output logic [30:0]      vlan_table_write_data,
    input  wire logic [30:0] vlan_table_read_data,
    input  wire logic        vlan_table_cmd_status,
    // diffserv table command port
    output logic             ds_table_command,
    output logic             ds_table_cmd_wr,
    output logic [5:0]       ds_table_cmd_idx,
    output logic [2:0]       ds_table_write_data,
    input  wire logic [2:0]  ds_table_read_data,
    input  wire logic        ds_table_cmd_status
);
    // command lines idle from time zero
    initial begin
        {vlan_table_command, vlan_table_cmd_wr, vlan_table_cmd_idx, vlan_table_write_data} = '0;
        {ds_table_command, ds_table_cmd_wr, ds_table_cmd_idx, ds_table_write_data} = '0;
    end

    // one command pulse, then a bounded wait for busy to fall before read data is taken
    task automatic cmd(input logic ds, input logic wr, input logic [5:0] idx, input logic [30:0] wd,
                       output logic [30:0] rd);
        int n;
        @(negedge sys_clk);
        {ds_table_command, vlan_table_command} = {ds, !ds};
        {ds_table_cmd_wr, vlan_table_cmd_wr} = {wr, wr};
        {ds_table_cmd_idx, vlan_table_cmd_idx} = {idx, idx[3:0]};
        {ds_table_write_data, vlan_table_write_data} = {wd[2:0], wd};
        @(negedge sys_clk);
        {ds_table_command, vlan_table_command} = 2'h0;
        n = 0;
        while ((ds ? ds_table_cmd_status : vlan_table_cmd_status) !== 1'b0 && n < 16) begin
            @(negedge sys_clk);
            n++;
        end
        rd = ds ? {28'h0, ds_table_read_data} : vlan_table_read_data;
    endtask : cmd

    // the diffserv table powers up undefined, so every entry is written before use
    task automatic fill_ds();
        logic [30:0] rd;
        for (int i = 0; i < 64; i++) begin
            cmd(1'b1, 1'b1, i[5:0], {28'h0, i[2:0] ^ 3'h6}, rd);
        end
    endtask : fill_ds
endmodule : host_model
`default_nettype wire

/* verification/switch_ingress_classifier_tb_top.sv */
// self-checking bench for the ingress classifier
`timescale 1ns/10ps
`default_nettype none
module switch_ingress_classifier_tb_top;
    // stimulus, results and table command nets
    logic        sys_clk, sys_rst, port_default_vlan_id_wr, pkt_valid, pkt_tagged, pkt_is_ipv4, pkt_is_ipv6;
    logic        pkt_da_found, pkt_da_static, pkt_da_age;
    logic [5:0]  global_ingress_config, port_tree_state_reg;
    logic [1:0]  port_default_vlan_id_port, pkt_src_port, pkt_da_queue;
    logic [2:0]  pkt_dst_ports, pkt_tag_prio;
    logic [14:0] port_default_vlan_id_wdata;
    logic [11:0] pkt_vid;
    logic [7:0]  pkt_tos;
    logic [30:0] rd;
    int          errors, samples_checked, cycles;
    wire logic   vlan_table_command, vlan_table_cmd_wr, vlan_table_cmd_status, res_valid, res_filter;
    wire logic   ds_table_command, ds_table_cmd_wr, ds_table_cmd_status, res_learn;
    wire logic [3:0]  vlan_table_cmd_idx;
    wire logic [5:0]  ds_table_cmd_idx;
    wire logic [30:0] vlan_table_write_data, vlan_table_read_data;
    wire logic [2:0]  ds_table_write_data, ds_table_read_data, res_src, res_member, res_untag, res_tx_ports;
    wire logic [1:0]  res_queue;
    wire logic [11:0] res_vid;
    localparam logic [15:0] tc_map = 16'h4e1b; // queue per priority

    ingress_classifier ingress_classifier_inst (.sys_clk, .sys_rst, .global_ingress_config,
        .port_tree_state_reg, .port0_priority_remap(8'h00), .port1_priority_remap(8'h08),
        .port2_priority_remap(8'h00), .traffic_class_map(tc_map), .hybrid_ports(3'h3), .port_default_vlan_id_wr,
        .port_default_vlan_id_port, .port_default_vlan_id_wdata, .vlan_table_command, .vlan_table_cmd_wr, .vlan_table_cmd_idx,
        .vlan_table_write_data, .vlan_table_read_data, .vlan_table_cmd_status, .ds_table_command,
        .ds_table_cmd_wr, .ds_table_cmd_idx, .ds_table_write_data, .ds_table_read_data,
        .ds_table_cmd_status, .pkt_valid, .pkt_src_port, .pkt_dst_ports, .pkt_da_found, .pkt_da_static,
        .pkt_da_age, .pkt_da_queue, .pkt_tagged, .pkt_vid, .pkt_tag_prio, .pkt_is_ipv4, .pkt_is_ipv6,
        .pkt_tos, .res_valid, .res_queue, .res_src, .res_member, .res_untag, .res_tx_ports,
        .res_filter, .res_learn, .res_vid);
    host_model host_model_inst (.sys_clk, .vlan_table_command, .vlan_table_cmd_wr, .vlan_table_cmd_idx,
        .vlan_table_write_data, .vlan_table_read_data, .vlan_table_cmd_status, .ds_table_command,
        .ds_table_cmd_wr, .ds_table_cmd_idx, .ds_table_write_data, .ds_table_read_data,
        .ds_table_cmd_status);

    // free-running clock and a ceiling on the run length
    always #5 sys_clk = ~sys_clk;
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 2000) begin
            errors++;
            stop_test();
        end
    end

    // compare and count
    task automatic chk(input string nm, input logic [30:0] e, input logic [30:0] g);
        samples_checked++;
        if (e !== g) begin
            errors++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    // mapped queue of a priority
    function automatic logic [1:0] tcq(input int p);
        return tc_map[2*p +: 2];
    endfunction : tcq

    // one packet descriptor; f is {ipv4, ipv6, found, static, age, dst ports, static queue}
    task automatic go(input logic [5:0] c, input logic t, input logic [11:0] v, input logic [7:0] tos,
                      input logic [9:0] f);
        @(negedge sys_clk);
        global_ingress_config = c;
        {pkt_src_port, pkt_tagged, pkt_vid, pkt_tos, pkt_tag_prio, pkt_is_ipv4, pkt_is_ipv6, pkt_da_found,
            pkt_da_static, pkt_da_age, pkt_dst_ports, pkt_da_queue} = {2'h1, t, v, tos, tos[2:0], f};
        pkt_valid = 1'b1;
        @(negedge sys_clk);
        pkt_valid = 1'b0;
        chk("res_valid", 31'h1, res_valid);
    endtask : go

    // closing report
    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : stop_test

    // main sequence
    initial begin
        sys_clk = 1'b0;
        sys_rst = 1'b1;
        {port_default_vlan_id_wr, port_default_vlan_id_port, port_default_vlan_id_wdata, pkt_valid, global_ingress_config, port_tree_state_reg} = '0;
        {pkt_src_port, pkt_tagged, pkt_vid, pkt_tos, pkt_tag_prio, pkt_is_ipv4, pkt_is_ipv6} = '0;
        {pkt_da_found, pkt_da_static, pkt_da_age, pkt_dst_ports, pkt_da_queue} = '0;
        repeat (8) @(negedge sys_clk);
        sys_rst = 1'b0;
        chk("res_valid", 31'h0, res_valid);
        host_model_inst.fill_ds();
        host_model_inst.cmd(1'b1, 1'b0, 6'h2d, 31'h0, rd);
        chk("ds_read", 31'h3, rd);
        host_model_inst.cmd(1'b0, 1'b1, 6'h0, {1'b1, 12'h123, 3'h3, 3'h2, 12'h0}, rd);
        host_model_inst.cmd(1'b0, 1'b1, 6'h1, {1'b1, 12'h005, 3'h7, 3'h5, 12'h0}, rd);
        host_model_inst.cmd(1'b0, 1'b0, 6'h0, 31'h0, rd);
        chk("vlan_read", {1'b1, 12'h123, 3'h3, 3'h2, 12'h0}, rd);
        @(negedge sys_clk);
        {port_default_vlan_id_wr, port_default_vlan_id_port, port_default_vlan_id_wdata} = {1'b1, 2'h1, 3'h6, 12'h005};
        @(negedge sys_clk);
        port_default_vlan_id_wr = 1'b0;
        // untagged and priority-tagged frames take the port default
        for (int t = 0; t < 2; t++) begin
            go(6'h10, t[0], 12'h000, 8'h00, 10'h012);
            chk("src_queue", {3'h4, tcq(6)}, {res_src, res_queue});
            chk("vid_member", {12'h005, 3'h7}, {res_vid, res_member});
        end
        go(6'h14, 1'b1, 12'h005, 8'ha0, 10'h212);
        chk("src_queue", {3'h1, tcq(5)}, {res_src, res_queue});
        go(6'h16, 1'b0, 12'h000, 8'hb4, 10'h112);
        chk("src_queue", {3'h2, tcq(3)}, {res_src, res_queue});
        go(6'h17, 1'b0, 12'h000, 8'hb4, 10'h2d2);
        chk("src_queue", {3'h0, 2'h2}, {res_src, res_queue});
        // tag priority 3 from port 1 regenerates to 7 through that port's row
        go(6'h18, 1'b1, 12'h123, 8'h03, 10'h012);
        chk("src_queue", {3'h3, tcq(7)}, {res_src, res_queue});
        go(6'h10, 1'b1, 12'h123, 8'h00, 10'h012);
        chk("member_untag", {3'h3, 3'h2}, {res_member, res_untag});
        go(6'h30, 1'b1, 12'h456, 8'h00, 10'h012);
        chk("member_filter", {3'h0, 1'b1}, {res_member, res_filter});
        go(6'h10, 1'b1, 12'hfff, 8'h00, 10'h012);
        chk("res_filter", 31'h1, res_filter);
        // every tree state on the source port
        for (int s = 0; s < 4; s++) begin
            port_tree_state_reg = {2'h0, s[1:0], 2'h0};
            go(6'h00, 1'b0, 12'h000, 8'h00, 10'h092);
            chk("filter_learn", {s != 0, s[0] == 1'b0}, {res_filter, res_learn});
        end
        // blocked destination, then the static plus age override
        port_tree_state_reg = 6'h10;
        for (int o = 0; o < 2; o++) begin
            go(6'h00, 1'b0, 12'h000, 8'h00, o[0] ? 10'h0f2 : 10'h092);
            chk("filter_tx", {!o[0], (o[0] ? 3'h4 : 3'h0)}, {res_filter, res_tx_ports});
        end
        stop_test();
    end
endmodule : switch_ingress_classifier_tb_top
`default_nettype wire
